// *** hw/pib_bridge.sv ***
// pib_bridge: pci target and initiator cycle control toward an isa bus
// assumes pci pins sampled synchronously to clk; arbiter grants with gnt_b
`timescale 1ns/100ps
module pib_bridge
  import pib_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic frame_in_b,
  input wire logic irdy_in_b,
  input wire logic devsel_in_b,
  input wire logic trdy_in_b,
  input wire logic [31:0] ad_in,
  input wire logic [3:0] cbe_in_b,
  input wire logic gnt_b,
  input wire logic post_en,
  input wire logic pos_decode,
  input wire logic [1:0] isa_width,
  input wire logic dma_req,
  input wire logic isa_master_req,
  input wire logic isa_fwd_req,
  input wire logic [31:0] isa_addr,
  input wire logic isa_write,
  input wire logic [31:0] isa_wdata,
  input wire logic [15:0] isa_rdata,
  input wire logic isa_ready,
  output logic req_b,
  output logic frame_out_b,
  output logic frame_oe,
  output logic irdy_out_b,
  output logic irdy_oe,
  output logic devsel_out_b,
  output logic trdy_out_b,
  output logic stop_out_b,
  output logic tgt_oe,
  output logic [31:0] ad_out,
  output logic ad_oe,
  output logic [3:0] cbe_out_b,
  output logic iochrdy_out,
  output logic iochrdy_oe,
  output logic isa_to_isa,
  output logic [1:0] isa_lane,
  output logic isa_cmd,
  output logic isa_wr,
  output logic [15:0] isa_data_out,
  output logic [31:0] isa_rd_out,
  output logic isa_done
);
  import pib_pkg::*;

  typedef struct packed {
    pib_state_t st;
    logic [3:0] win;
    logic [3:0] div;
    logic tick;
    logic [31:0] addr;
    logic [3:0] cmd;
    logic [3:0] be_b;
    logic wr;
    logic [31:0] data;
    logic seq_go;
    logic posted;
    logic dly_pend;
    logic dly_busy;
    logic [31:0] dly_addr;
    logic req_b;
    logic frame_b;
    logic frame_oe;
    logic irdy_b;
    logic irdy_oe;
    logic devsel_b;
    logic trdy_b;
    logic stop_b;
    logic tgt_oe;
    logic [31:0] ad;
    logic ad_oe;
    logic [3:0] cbe_b;
    logic iochrdy;
    logic iochrdy_oe;
    logic isa_only;
    logic [PIB_PTR_W-1:0] wp;
    logic [PIB_PTR_W-1:0] rp;
  } pib_bridge_t;
  pib_bridge_t r_reg, r_next;

  // line buffers between the two sides
  logic [PIB_LINE_W-1:0] line_reg [PIB_LINES];
  logic seq_done;
  logic [31:0] seq_rdata;
  logic [1:0] seq_lane;
  logic seq_cmd;
  logic seq_wr;
  logic [15:0] seq_wdata;

  function automatic logic is_mem_write(input logic [3:0] c);
    is_mem_write = (c == PIB_CMD_MWR);
    return is_mem_write;
  endfunction

  pib_isa_seq u_seq (
    .clk(clk),
    .rst_b(rst_b),
    .isa_tick(r_reg.tick),
    .start(r_reg.seq_go),
    .write(r_reg.wr),
    .byte_en_b(r_reg.be_b),
    .width(isa_width),
    .wdata(r_reg.data),
    .isa_rdata(isa_rdata),
    .isa_ready(isa_ready),
    .isa_lane(seq_lane),
    .isa_cmd(seq_cmd),
    .isa_wr(seq_wr),
    .isa_wdata(seq_wdata),
    .rdata(seq_rdata),
    .done(seq_done)
  );

  always_comb begin
    r_next = r_reg;
    r_next.seq_go = 1'b0;
    // isa strobe rate from the pci clock, no second clock source
    r_next.tick = 1'b0;
    if (r_reg.div == 4'(PIB_ISA_DIV - 1)) begin
      r_next.div = 4'h0;
      r_next.tick = 1'b1;
    end else begin
      r_next.div = r_reg.div + 4'h1;
    end
    r_next.trdy_b = 1'b1;
    r_next.stop_b = 1'b1;
    case (r_reg.st)
      PIB_IDLE: begin
        r_next.devsel_b = 1'b1;
        r_next.tgt_oe = 1'b0;
        r_next.iochrdy_oe = 1'b0;
        r_next.iochrdy = 1'b1;
        if ((dma_req || isa_master_req) && isa_fwd_req && !r_reg.posted && !r_reg.dly_busy) begin
          r_next.req_b = 1'b0;
          r_next.addr = isa_addr;
          r_next.wr = isa_write;
          r_next.data = isa_wdata;
          r_next.cmd = isa_write ? PIB_CMD_MWR : PIB_CMD_MRD;
          r_next.iochrdy = 1'b0;
          r_next.iochrdy_oe = 1'b1;
          r_next.st = PIB_M_REQ;
        end else if (!frame_in_b && gnt_b) begin
          // target only while the bus is not ours
          r_next.addr = ad_in;
          r_next.cmd = cbe_in_b;
          r_next.wr = cbe_in_b[0];
          r_next.win = 4'h0;
          r_next.st = PIB_T_DECODE;
          if (pos_decode) begin
            r_next.devsel_b = 1'b0;
            r_next.tgt_oe = 1'b1;
            r_next.st = PIB_T_WAIT_DATA;
          end
        end
      end
      PIB_T_DECODE: begin
        r_next.win = r_reg.win + 4'h1;
        if (!devsel_in_b) begin
          r_next.st = PIB_IDLE;
        end else if (r_reg.win == 4'(PIB_DECODE_CLKS - 1)) begin
          r_next.devsel_b = 1'b0;
          r_next.tgt_oe = 1'b1;
          r_next.st = PIB_T_WAIT_DATA;
        end
      end
      PIB_T_WAIT_DATA: begin
        if (!irdy_in_b) begin
          r_next.be_b = cbe_in_b;
          r_next.data = ad_in;
          // retry unless a write finds the isa side free or a delayed read is ready
          r_next.stop_b = 1'b0;
          r_next.st = PIB_T_DONE;
          if (!r_reg.posted && !r_reg.dly_busy) begin
            if (r_reg.wr && is_mem_write(r_reg.cmd) && post_en) begin
              r_next.trdy_b = 1'b0;
              r_next.posted = 1'b1;
              r_next.seq_go = 1'b1;
            end else if (r_reg.wr) begin
              r_next.stop_b = 1'b1;
              r_next.seq_go = 1'b1;
              r_next.st = PIB_T_ISA;
            end else if (r_reg.dly_pend && r_reg.dly_addr == r_reg.addr) begin
              // completion of an earlier delayed read
              r_next.trdy_b = 1'b0;
              r_next.ad = line_reg[r_reg.rp];
              r_next.ad_oe = 1'b1;
              r_next.dly_pend = 1'b0;
            end else if (!r_reg.dly_pend) begin
              // limitation: an abandoned delayed read blocks other reads
              r_next.seq_go = 1'b1;
              r_next.dly_busy = 1'b1;
              r_next.dly_addr = r_reg.addr;
            end
          end
        end
      end
      PIB_T_ISA: begin
        if (seq_done) begin
          r_next.trdy_b = 1'b0;
          r_next.stop_b = 1'b0;
          r_next.ad = seq_rdata;
          r_next.ad_oe = !r_reg.wr;
          r_next.st = PIB_T_DONE;
        end
      end
      PIB_T_DONE: begin
        r_next.devsel_b = 1'b1;
        r_next.ad_oe = 1'b0;
        if (frame_in_b) begin
          r_next.tgt_oe = 1'b0;
          r_next.st = PIB_IDLE;
        end
      end
      PIB_M_REQ: begin
        if (!gnt_b && frame_in_b && irdy_in_b) begin
          r_next.frame_b = 1'b0;
          r_next.frame_oe = 1'b1;
          r_next.irdy_oe = 1'b1;
          r_next.ad = r_reg.addr;
          r_next.ad_oe = 1'b1;
          r_next.cbe_b = r_reg.cmd;
          r_next.win = 4'h0;
          r_next.st = PIB_M_ADDR;
        end
      end
      PIB_M_ADDR: begin
        r_next.req_b = 1'b1;
        r_next.frame_b = 1'b1;
        r_next.irdy_b = 1'b0;
        r_next.ad = r_reg.data;
        r_next.ad_oe = r_reg.wr;
        r_next.cbe_b = 4'h0;
        r_next.win = r_reg.win + 4'h1;
        r_next.st = PIB_M_DATA;
      end
      PIB_M_DATA: begin
        r_next.win = r_reg.win + 4'h1;
        if (!devsel_in_b && !trdy_in_b) begin
          if (!r_reg.wr) begin
            r_next.wp = r_reg.wp + 3'h1;
          end
          r_next.isa_only = 1'b0;
          r_next.st = PIB_T_DONE;
        end else if (devsel_in_b && r_reg.win == 4'(PIB_DECODE_CLKS)) begin
          r_next.isa_only = 1'b1;
          r_next.st = PIB_T_DONE;
        end
        if (r_next.st == PIB_T_DONE) begin
          r_next.irdy_b = 1'b1;
          r_next.ad_oe = 1'b0;
          r_next.iochrdy = 1'b1;
        end
      end
      default: r_next.st = PIB_IDLE;
    endcase
    if (r_reg.st == PIB_T_DONE && frame_in_b && r_reg.irdy_oe) begin
      r_next.frame_oe = 1'b0;
      r_next.irdy_oe = 1'b0;
      r_next.cbe_b = 4'hF;
    end
    // the drained posted write frees the target for new cycles
    if (seq_done && r_reg.posted) begin
      r_next.posted = 1'b0;
    end
    if (seq_done && r_reg.dly_busy) begin
      r_next.dly_busy = 1'b0;
      r_next.dly_pend = 1'b1;
      r_next.rp = r_reg.wp;
      r_next.wp = r_reg.wp + 3'h1;
    end
    // ownership selects isa-pci vs isa-isa; both paths kept
    if (r_reg.st == PIB_M_REQ && !isa_fwd_req) begin
      r_next.isa_only = 1'b1;
      r_next.req_b = 1'b1;
      r_next.iochrdy = 1'b1;
      r_next.st = PIB_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r_reg <= '0;
      r_reg.st <= PIB_IDLE;
      r_reg.req_b <= 1'b1;
      r_reg.frame_b <= 1'b1;
      r_reg.irdy_b <= 1'b1;
      r_reg.devsel_b <= 1'b1;
      r_reg.trdy_b <= 1'b1;
      r_reg.stop_b <= 1'b1;
      r_reg.cbe_b <= 4'hF;
      r_reg.iochrdy <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  always_ff @(posedge clk) begin
    if (r_reg.st == PIB_M_DATA && !devsel_in_b && !trdy_in_b) begin
      line_reg[r_reg.wp] <= ad_in;
    end else if (seq_done && r_reg.dly_busy) begin
      line_reg[r_reg.wp] <= seq_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      isa_lane <= 2'h0;
      isa_cmd <= 1'b0;
      isa_wr <= 1'b0;
      isa_data_out <= 16'h0000;
      isa_rd_out <= 32'h0000_0000;
      isa_done <= 1'b0;
    end else begin
      isa_lane <= seq_lane;
      isa_cmd <= seq_cmd;
      isa_wr <= seq_wr;
      isa_data_out <= seq_wdata;
      isa_rd_out <= seq_rdata;
      isa_done <= seq_done;
    end
  end

  assign req_b = r_reg.req_b;
  assign frame_out_b = r_reg.frame_b;
  assign frame_oe = r_reg.frame_oe;
  assign irdy_out_b = r_reg.irdy_b;
  assign irdy_oe = r_reg.irdy_oe;
  assign devsel_out_b = r_reg.devsel_b;
  assign trdy_out_b = r_reg.trdy_b;
  assign stop_out_b = r_reg.stop_b;
  assign tgt_oe = r_reg.tgt_oe;
  assign ad_out = r_reg.ad;
  assign ad_oe = r_reg.ad_oe;
  assign cbe_out_b = r_reg.cbe_b;
  assign iochrdy_out = r_reg.iochrdy;
  assign iochrdy_oe = r_reg.iochrdy_oe;
  assign isa_to_isa = r_reg.isa_only;
endmodule

// *** hw/pib_isa_seq.sv ***
// pib_isa_seq: runs split isa cycles for one pci data phase
// assumes start pulse with stable address, byte enables and width
`timescale 1ns/100ps
module pib_isa_seq
  import pib_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic isa_tick,
  input wire logic start,
  input wire logic write,
  input wire logic [3:0] byte_en_b,
  input wire logic [1:0] width,
  input wire logic [31:0] wdata,
  input wire logic [15:0] isa_rdata,
  input wire logic isa_ready,
  output logic [1:0] isa_lane,
  output logic isa_cmd,
  output logic isa_wr,
  output logic [15:0] isa_wdata,
  output logic [31:0] rdata,
  output logic done
);
  typedef struct packed {
    logic busy;
    logic [3:0] left_b;
    logic [1:0] lane;
    logic [2:0] cnt;
    logic cmd;
    logic wr;
    logic [31:0] data;
    logic done;
  } pib_seq_t;
  pib_seq_t s_reg, s_next;

  // first pending byte lane, aligned down to an even lane for any width but 8-bit
  function automatic logic [1:0] pick(input logic [3:0] left_b, input logic [1:0] w);
    logic [1:0] l;
    l = !left_b[0] ? 2'h0 : !left_b[1] ? 2'h1 : !left_b[2] ? 2'h2 : 2'h3;
    pick = (w == PIB_WID_8) ? l : {l[1], 1'b0};
    return pick;
  endfunction

  function automatic logic [3:0] mask(input logic [1:0] l, input logic [1:0] w);
    mask = (w == PIB_WID_8) ? (4'h1 << l) : (4'h3 << l);
    return mask;
  endfunction

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (start && !s_reg.busy) begin
      s_next.busy = 1'b1;
      s_next.left_b = (width == PIB_WID_32) ? 4'hF & ~4'h0 & byte_en_b : byte_en_b;
      s_next.data = wdata;
      s_next.cnt = 3'h0;
      // direction latched here: later pci cycles rewrite the bridge's copy
      s_next.wr = write;
    end else if (s_reg.busy && isa_tick) begin
      if (!s_reg.cmd) begin
        if (&s_reg.left_b) begin
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
        end else begin
          s_next.lane = pick(s_reg.left_b, width);
          s_next.cmd = 1'b1;
          s_next.cnt = 3'h0;
        end
      end else if (s_reg.cnt < 3'(PIB_ISA_CMD_CLKS)) begin
        s_next.cnt = s_reg.cnt + 3'h1;
      end else if (isa_ready) begin
        s_next.cmd = 1'b0;
        s_next.left_b = s_reg.left_b | mask(s_reg.lane, width);
        if (!s_reg.wr) begin
          // read bytes collected in place before returning to pci
          s_next.data[8*s_reg.lane +: 8] = isa_rdata[7:0];
          if (width != PIB_WID_8) begin
            s_next.data[8*s_reg.lane + 8 +: 8] = isa_rdata[15:8];
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign isa_lane = s_reg.lane;
  assign isa_cmd = s_reg.cmd;
  assign isa_wr = s_reg.wr;
  assign isa_wdata = 16'(s_reg.data >> (8*s_reg.lane));
  assign rdata = s_reg.data;
  assign done = s_reg.done;
endmodule

// *** hw/pib_pkg.sv ***
// pib_pkg: shared constants and types for the pci/isa cycle bridge
// assumes a 100 MHz clock; isa timing derived as enable pulses
package pib_pkg;
  localparam int PIB_CLK_NS = 10;
  localparam int PIB_ISA_NS = 120;
  localparam int PIB_ISA_DIV = (PIB_ISA_NS + PIB_CLK_NS - 1) / PIB_CLK_NS;
  localparam int PIB_DECODE_CLKS = 4;
  localparam int PIB_LINES = 8;
  localparam int PIB_LINE_W = 32;
  localparam int PIB_PTR_W = 3;
  localparam int PIB_ISA_CMD_CLKS = 3;
  localparam logic [3:0] PIB_CMD_IORD = 4'h2;
  localparam logic [3:0] PIB_CMD_IOWR = 4'h3;
  localparam logic [3:0] PIB_CMD_MRD = 4'h6;
  localparam logic [3:0] PIB_CMD_MWR = 4'h7;
  localparam logic [1:0] PIB_WID_8 = 2'h0;
  localparam logic [1:0] PIB_WID_16 = 2'h1;
  localparam logic [1:0] PIB_WID_32 = 2'h2;

  typedef enum logic [7:0] {
    PIB_IDLE = 8'h01,
    PIB_T_DECODE = 8'h02,
    PIB_T_WAIT_DATA = 8'h04,
    PIB_T_ISA = 8'h08,
    PIB_T_DONE = 8'h10,
    PIB_M_REQ = 8'h20,
    PIB_M_ADDR = 8'h40,
    PIB_M_DATA = 8'h80
  } pib_state_t;
endpackage

// *** verif/pib_bridge_checker.sv ***
// pib_bridge_checker: concurrent checks on the bridge pins
// assumes pci inputs carry wire levels; bound into pib_bridge
`timescale 1ns/100ps
module pib_bridge_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic frame_in_b,
  input wire logic irdy_in_b,
  input wire logic devsel_in_b,
  input wire logic gnt_b,
  input wire logic pos_decode,
  input wire logic dma_req,
  input wire logic isa_master_req,
  input wire logic isa_fwd_req,
  input wire logic req_b,
  input wire logic frame_oe,
  input wire logic frame_out_b,
  input wire logic irdy_oe,
  input wire logic devsel_out_b,
  input wire logic trdy_out_b,
  input wire logic stop_out_b,
  input wire logic tgt_oe,
  input wire logic iochrdy_out,
  input wire logic iochrdy_oe,
  input wire logic isa_cmd,
  input wire logic isa_wr,
  input wire logic isa_to_isa,
  input wire logic isa_done
);
  logic irdy_seen_reg;
  // set priority keeps a drain from hiding a back-to-back transaction's irdy
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irdy_seen_reg <= 1'b0;
    end else if (!irdy_in_b && !irdy_oe) begin
      irdy_seen_reg <= 1'b1;
    end else if (isa_done) begin
      irdy_seen_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_tgt_addr;
    $fell(frame_in_b) && !pos_decode && !frame_oe && !tgt_oe;
  endsequence
  sequence s_unclaimed;
    s_tgt_addr ##1 (devsel_in_b && !tgt_oe)[*4];
  endsequence
  sequence s_other;
    s_tgt_addr ##[1:3] (!devsel_in_b && !tgt_oe);
  endsequence
  sequence s_fwd_none;
    $rose(frame_oe) ##1 devsel_in_b[*5];
  endsequence
  sequence s_fwd_hit;
    $rose(frame_oe) ##[1:4] !devsel_in_b;
  endsequence

  a_req_on_fwd: assert property ($rose((dma_req || isa_master_req) && isa_fwd_req)
    |-> ##[1:2] !req_b) else $error("no bus request");
  a_grant_first: assert property ($rose(frame_oe) |-> $past(gnt_b) == 1'b0)
    else $error("frame without grant");
  a_iochrdy_hold: assert property (frame_oe && !frame_out_b |-> iochrdy_oe && !iochrdy_out)
    else $error("isa cycle not held");
  a_master_abort: assert property (s_fwd_none |-> ##[0:4] (!irdy_oe && isa_to_isa))
    else $error("no master abort");
  a_fwd_done: assert property (s_fwd_hit |-> ##[1:16] (!irdy_oe && !isa_to_isa))
    else $error("claimed cycle not completed");
  a_pos_claim: assert property ($fell(frame_in_b) && pos_decode && !frame_oe && !tgt_oe
    |=> tgt_oe && !devsel_out_b) else $error("decoded cycle not claimed");
  a_other_desel: assert property (s_other |=> (!tgt_oe)[*4])
    else $error("claimed another agent's cycle");
  a_sub_claim: assert property (s_unclaimed |-> ##[0:2] (tgt_oe && !devsel_out_b))
    else $error("unclaimed cycle not taken");
  a_write_irdy: assert property ($rose(isa_cmd) && isa_wr && !iochrdy_oe |-> irdy_seen_reg)
    else $error("isa write before irdy");
  a_one_phase: assert property (tgt_oe && !trdy_out_b && !stop_out_b
    |=> trdy_out_b || !tgt_oe) else $error("second data phase");
endmodule

bind pib_bridge pib_bridge_checker u_chk (.clk, .rst_b, .frame_in_b, .irdy_in_b, .devsel_in_b,
  .gnt_b, .pos_decode, .dma_req, .isa_master_req, .isa_fwd_req, .req_b, .frame_oe, .frame_out_b,
  .irdy_oe, .devsel_out_b, .trdy_out_b, .stop_out_b, .tgt_oe, .iochrdy_out, .iochrdy_oe,
  .isa_cmd, .isa_wr, .isa_to_isa, .isa_done);

// *** verif/pib_pci_partner.sv ***
// pib_pci_partner: arbiter, a medium-speed pci target and isa devices
// assumes wire levels of frame and irdy; released lines read high
`timescale 1ns/100ps
module pib_pci_partner (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic claim,
  input wire logic frame_in_b,
  input wire logic irdy_in_b,
  input wire logic req_b,
  input wire logic isa_cmd,
  input wire logic isa_wr,
  input wire logic [1:0] isa_lane,
  output logic gnt_b,
  output logic devsel_b,
  output logic trdy_b,
  output logic isa_ready,
  output logic [15:0] isa_rdata
);
  logic [1:0] dcnt;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gnt_b <= 1'b1;
      devsel_b <= 1'b1;
      trdy_b <= 1'b1;
      dcnt <= 2'h0;
      isa_ready <= 1'b0;
      isa_rdata <= 16'h0000;
    end else begin
      gnt_b <= req_b;
      if (frame_in_b && irdy_in_b) begin
        dcnt <= 2'h0;
        devsel_b <= 1'b1;
        trdy_b <= 1'b1;
      end else if (claim) begin
        dcnt <= (dcnt == 2'h3) ? dcnt : dcnt + 2'h1;
        devsel_b <= !(dcnt >= 2'h1);
        trdy_b <= !(dcnt >= 2'h2);
      end
      isa_ready <= isa_cmd;
      // undriven data toggles so a stale sample cannot pass
      isa_rdata <= (isa_cmd && !isa_wr) ? {2{8'h11 * (8'(isa_lane) + 8'h01)}} : ~isa_rdata;
    end
  end
endmodule

// *** verif/tb_pci_to_isa_cycle_bridge.sv ***
// tb_pci_to_isa_cycle_bridge: directed target and initiator scenarios
// assumes pib_pkg, pib_bridge, checker and partner compiled first
`timescale 1ns/100ps
module tb_pci_to_isa_cycle_bridge;
  import pib_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic fr_b = 1'b1;
  logic ir_b = 1'b1;
  logic claim = 1'b0;
  logic post_en = 1'b0;
  logic pos_decode = 1'b0;
  logic [1:0] isa_width = PIB_WID_8;
  logic dma_req = 1'b0;
  logic isa_master_req = 1'b0;
  logic isa_fwd_req = 1'b0;
  logic [31:0] isa_addr = 32'h0000_0170;
  logic isa_write = 1'b0;
  logic [31:0] isa_wdata = 32'hCAFE_0F0D;
  logic [31:0] tb_ad = 32'h0000_0000;
  logic [3:0] tb_cbe = 4'hF;
  logic frame_in_b, irdy_in_b, devsel_in_b, trdy_in_b, gnt_b, p_dev_b, p_trdy_b, isa_ready;
  logic req_b, frame_out_b, frame_oe, irdy_out_b, irdy_oe, devsel_out_b, trdy_out_b, stop_out_b;
  logic tgt_oe, ad_oe, iochrdy_out, iochrdy_oe, isa_to_isa, isa_cmd, isa_wr, isa_done;
  logic [31:0] ad_in, ad_out, isa_rd_out;
  logic [3:0] cbe_in_b, cbe_out_b;
  logic [1:0] isa_lane;
  logic [15:0] isa_rdata, isa_data_out;
  int error_cnt = 0;
  int cmp_count = 0;
  int tmo = 0;

  assign frame_in_b = frame_oe ? frame_out_b : fr_b;
  assign irdy_in_b = irdy_oe ? irdy_out_b : ir_b;
  assign devsel_in_b = tgt_oe ? devsel_out_b : p_dev_b;
  assign trdy_in_b = tgt_oe ? trdy_out_b : p_trdy_b;
  assign ad_in = ad_oe ? ad_out : tb_ad;
  assign cbe_in_b = ad_oe ? cbe_out_b : tb_cbe;

  pib_bridge dut (.clk, .rst_b, .frame_in_b, .irdy_in_b, .devsel_in_b, .trdy_in_b, .ad_in,
    .cbe_in_b, .gnt_b, .post_en, .pos_decode, .isa_width, .dma_req, .isa_master_req,
    .isa_fwd_req, .isa_addr, .isa_write, .isa_wdata, .isa_rdata, .isa_ready, .req_b,
    .frame_out_b, .frame_oe, .irdy_out_b, .irdy_oe, .devsel_out_b, .trdy_out_b, .stop_out_b,
    .tgt_oe, .ad_out, .ad_oe, .cbe_out_b, .iochrdy_out, .iochrdy_oe, .isa_to_isa, .isa_lane,
    .isa_cmd, .isa_wr, .isa_data_out, .isa_rd_out, .isa_done);
  pib_pci_partner u_partner (.clk, .rst_b, .claim, .frame_in_b, .irdy_in_b, .req_b, .isa_cmd,
    .isa_wr, .isa_lane, .gnt_b, .devsel_b(p_dev_b), .trdy_b(p_trdy_b), .isa_ready, .isa_rdata);

  always #5 clk = ~clk;

  task automatic cyc;
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // single-phase transaction, repeated while the bridge answers with retry
  task automatic tgt(input logic [3:0] cmd, input logic pd, input int idl, output int dly,
      output int wt, output logic [31:0] rd);
    logic ok;
    ok = 1'b0;
    for (int a = 0; a < 100 && !ok; a++) begin
      tb_ad = 32'h0000_0300;
      tb_cbe = cmd;
      fr_b = 1'b0;
      pos_decode = pd;
      cyc;
      pos_decode = 1'b0;
      tb_cbe = 4'h0;
      tb_ad = 32'h1234_5678;
      dly = 1;
      while (devsel_out_b !== 1'b0 && dly < 12) begin
        chk("isa_cmd_before_irdy", 32'h0, isa_cmd && isa_wr && cmd[0] && a == 0);
        cyc;
        dly++;
      end
      repeat (idl) begin
        chk("isa_cmd_before_irdy", 32'h0, isa_cmd && isa_wr && cmd[0] && a == 0);
        cyc;
      end
      fr_b = 1'b1;
      ir_b = 1'b0;
      wt = 0;
      while (stop_out_b !== 1'b0 && wt < 800) begin
        cyc;
        wt++;
      end
      ok = (trdy_out_b === 1'b0);
      rd = ad_out;
      cyc;
      ir_b = 1'b1;
      cyc;
    end
    chk("tgt_data_moved", 32'h1, ok);
  endtask

  task automatic t_post_read;
    int dly, wt, n;
    logic [31:0] rd;
    post_en = 1'b1;
    tgt(PIB_CMD_MWR, 1'b1, 3, dly, wt, rd);
    chk("pos_devsel_dly", 32'h1, dly);
    chk("posted_ack_fast", 32'h1, wt <= 2);
    n = 0;
    while (!(isa_cmd === 1'b1 && isa_wr === 1'b1) && n < 40) begin
      cyc;
      n++;
    end
    chk("post_first_lane", 32'h0, isa_lane);
    chk("post_first_byte", 32'h78, isa_data_out[7:0]);
    tgt(PIB_CMD_IORD, 1'b0, 0, dly, wt, rd);
    chk("sub_devsel_dly", 32'h1, dly >= PIB_DECODE_CLKS && dly <= PIB_DECODE_CLKS + 1);
    chk("split_read_ad", 32'h4433_2211, rd);
    chk("split_read_latch", 32'h4433_2211, isa_rd_out);
    post_en = 1'b0;
  endtask

  task automatic t_other;
    int n;
    claim = 1'b1;
    tb_ad = 32'h0000_0400;
    tb_cbe = PIB_CMD_MRD;
    fr_b = 1'b0;
    cyc;
    fr_b = 1'b1;
    ir_b = 1'b0;
    tb_cbe = 4'h0;
    n = 0;
    while ((p_trdy_b !== 1'b0 || n < 8) && n < 20) begin
      chk("other_tgt_oe", 32'h0, tgt_oe);
      cyc;
      n++;
    end
    cyc;
    ir_b = 1'b1;
    claim = 1'b0;
    cyc;
  endtask

  task automatic t_mst(input logic c, input logic im);
    int n;
    logic r;
    claim = c;
    dma_req = !im;
    isa_master_req = im;
    isa_fwd_req = 1'b1;
    n = 0;
    r = 1'b0;
    while (frame_oe !== 1'b1 && n < 20) begin
      r = r | (req_b === 1'b0);
      cyc;
      n++;
    end
    chk("req_seen", 32'h1, r);
    chk("gnt_at_frame", 32'h0, gnt_b);
    chk("iochrdy_held", 32'h1, iochrdy_oe && !iochrdy_out);
    while ((frame_oe !== 1'b0 || irdy_oe !== 1'b0) && n < 80) begin
      cyc;
      n++;
    end
    dma_req = 1'b0;
    isa_master_req = 1'b0;
    isa_fwd_req = 1'b0;
    claim = 1'b0;
    cyc;
    cyc;
    chk("isa_to_isa", !c, isa_to_isa);
  endtask

  task automatic t_local;
    dma_req = 1'b1;
    repeat (10) begin
      cyc;
      chk("local_no_req", 32'h1, req_b);
    end
    dma_req = 1'b0;
    cyc;
  endtask

  always @(posedge clk) begin
    tmo++;
    if (tmo == 40000) begin
      error_cnt++;
      print_verdict;
    end
  end

  initial begin
    repeat (4) cyc;
    rst_b = 1'b1;
    cyc;
    t_post_read;
    t_other;
    t_mst(1'b1, 1'b0);
    t_mst(1'b0, 1'b1);
    t_local;
    print_verdict;
  end
endmodule
